// *** rtl/fcr_cfg.svh ***
// Purpose: Offsets, field positions, reset values for the reload block.
// Assumes: Register indices are word numbers; byte address is index * 4.
// Notes:   Definitions only, no logic.
`ifndef FCR_CFG_SVH
`define FCR_CFG_SVH

// Register indices, each a 32-bit word at byte address index * 4.
`define FCR_IDX_CTRL        8'h00
`define FCR_IDX_NORM_AMP    8'h01
`define FCR_IDX_NORM_FREQ   8'h02
`define FCR_IDX_STATUS      8'h03
`define FCR_IDX_SPACE_AMP   8'h45
`define FCR_IDX_SPACE_FREQ  8'h46
`define FCR_IDX_MARK_AMP    8'h47
`define FCR_IDX_MARK_FREQ   8'h48
`define FCR_IDX_S2M_GAIN    8'h49
`define FCR_IDX_M2S_GAIN    8'h4A

// Slots of the shift-keying coefficient array.
`define FCR_SLOT_SPACE_AMP  3'h0
`define FCR_SLOT_SPACE_FREQ 3'h1
`define FCR_SLOT_MARK_AMP   3'h2
`define FCR_SLOT_MARK_FREQ  3'h3
`define FCR_SLOT_S2M_GAIN   3'h4
`define FCR_SLOT_M2S_GAIN   3'h5
`define FCR_NUM_SLOTS       6

// Control word fields.
`define FCR_CTRL_FSK_EN_BIT 0
`define FCR_CTRL_RELOAD_EN_BIT 1

// Reset values.
`define FCR_RST_CTRL        2'h0
`define FCR_RST_COEF        16'h0000

// Fraction bits of the gain factor (gain 1.0 is 1 << this).
`define FCR_GAIN_FRAC       14

`endif

// *** rtl/fcr_pkg.sv ***
// Purpose: Types shared by the reload block.
// Assumes: Constants live in fcr_cfg.svh.
// Notes:   No imports; users write fcr_pkg::name.
package fcr_pkg;

  // One 16-bit oscillator coefficient.
  typedef logic [15:0] fcr_coef_t;

  // Which coefficient pair was loaded into the first oscillator last.
  typedef enum logic [1:0] {
    FCR_SRC_NORMAL,
    FCR_SRC_SPACE,
    FCR_SRC_MARK
  } fcr_src_t;

endpackage

// *** rtl/fcr_top.sv ***
// Purpose: Shift-keying coefficient reload for the first tone oscillator.
// Assumes: Expiry strobe and bit to send come from logic on pclk.
// Notes:   APB slave, one wait state on every access.
//
// Behaviour
// - Space sent with both flags: load space amplitude on timer expiry.
// - Space sent with both flags: load space frequency on timer expiry.
// - Mark sent with both flags: load mark amplitude on timer expiry.
// - Mark sent with both flags: load mark frequency on timer expiry.
// - Space-to-mark change scales amplitude by space-to-mark gain factor.
// - Mark-to-space change scales amplitude by mark-to-space gain factor.
// - Hardware reset puts all control and coefficient registers at default.
//
// Decided for this implementation: register access over APB.
`timescale 1ns/100ps
`include "fcr_cfg.svh"

module fcr_top #(
  parameter int GAIN_FRAC = `FCR_GAIN_FRAC
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              osc_timer_expire,
  input  wire logic              tx_bit,
  output fcr_pkg::fcr_coef_t     first_oscillator_amplitude_coef,
  output fcr_pkg::fcr_coef_t     first_oscillator_frequency_coef,
  output logic                   first_oscillator_load,
  output logic                   gain_applied
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Scales an amplitude by a fixed-point gain, saturating rather than
  // wrapping so a large factor cannot fold a loud tone into a quiet one.
  function automatic fcr_pkg::fcr_coef_t scale_amp(
    input fcr_pkg::fcr_coef_t amp,
    input fcr_pkg::fcr_coef_t gain
  );
    logic [31:0] prod;
    logic [31:0] shifted;
    prod    = 32'(amp) * 32'(gain);
    shifted = prod >> GAIN_FRAC;
    if (shifted[31:16] != 16'h0000) begin
      scale_amp = 16'hFFFF;
    end else begin
      scale_amp = shifted[15:0];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State.

  logic               [1:0]  ctrl_q;
  logic               [1:0]  ctrl_d;
  fcr_pkg::fcr_coef_t        norm_amp_q;
  fcr_pkg::fcr_coef_t        norm_amp_d;
  fcr_pkg::fcr_coef_t        norm_freq_q;
  fcr_pkg::fcr_coef_t        norm_freq_d;
  fcr_pkg::fcr_coef_t        fsk_q [`FCR_NUM_SLOTS];
  fcr_pkg::fcr_coef_t        fsk_d [`FCR_NUM_SLOTS];
  logic               [31:0] prdata_q;
  logic               [31:0] prdata_d;
  logic                      pready_q;
  logic                      pready_d;
  logic                      pslverr_q;
  logic                      pslverr_d;
  fcr_pkg::fcr_coef_t        amp_q;
  fcr_pkg::fcr_coef_t        amp_d;
  fcr_pkg::fcr_coef_t        freq_q;
  fcr_pkg::fcr_coef_t        freq_d;
  logic                      load_q;
  logic                      load_d;
  logic                      gain_q;
  logic                      gain_d;
  fcr_pkg::fcr_src_t         src_q;
  fcr_pkg::fcr_src_t         src_d;
  logic                      prev_bit_q;
  logic                      prev_bit_d;
  logic                      have_prev_q;
  logic                      have_prev_d;

  logic               [7:0]  idx;
  logic                      access;
  logic                      commit;
  logic                      mapped;
  logic                      fsk_on;
  logic                      change;
  fcr_pkg::fcr_coef_t        space_amp;
  fcr_pkg::fcr_coef_t        space_freq;
  fcr_pkg::fcr_coef_t        mark_amp;
  fcr_pkg::fcr_coef_t        mark_freq;
  fcr_pkg::fcr_coef_t        s2m_gain;
  fcr_pkg::fcr_coef_t        m2s_gain;

  // Named views of the coefficient slots.
  assign space_amp  = fsk_q[`FCR_SLOT_SPACE_AMP];
  assign space_freq = fsk_q[`FCR_SLOT_SPACE_FREQ];
  assign mark_amp   = fsk_q[`FCR_SLOT_MARK_AMP];
  assign mark_freq  = fsk_q[`FCR_SLOT_MARK_FREQ];
  assign s2m_gain   = fsk_q[`FCR_SLOT_S2M_GAIN];
  assign m2s_gain   = fsk_q[`FCR_SLOT_M2S_GAIN];

  // Bus decode; the write lands on the edge where pready is seen high.
  assign idx    = paddr[9:2];
  assign access = psel & penable;
  assign commit = access & pready_q;
  assign mapped = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0) &&
                  ((idx <= `FCR_IDX_STATUS) ||
                   ((idx >= `FCR_IDX_SPACE_AMP) &&
                    (idx <= `FCR_IDX_M2S_GAIN)));

  // Enhanced mode needs both flags; a transition needs a previous symbol.
  assign fsk_on = ctrl_q[`FCR_CTRL_FSK_EN_BIT] &
                  ctrl_q[`FCR_CTRL_RELOAD_EN_BIT];
  assign change = have_prev_q & (prev_bit_q != tx_bit);

  ////////////////////////////////////////////////////////////////////////////
  // Register file and APB answer.

  // Reads are captured together with pready so data is stable when seen.
  always_comb begin
    ctrl_d      = ctrl_q;
    norm_amp_d  = norm_amp_q;
    norm_freq_d = norm_freq_q;
    fsk_d       = fsk_q;
    pready_d    = access & ~pready_q;
    pslverr_d   = 1'b0;
    prdata_d    = prdata_q;
    if (access && !pready_q) begin
      pslverr_d = ~mapped;
      prdata_d  = 32'h0000_0000;
      if (mapped && !pwrite) begin
        unique case (idx)
          `FCR_IDX_CTRL:      prdata_d[1:0]  = ctrl_q;
          `FCR_IDX_NORM_AMP:  prdata_d[15:0] = norm_amp_q;
          `FCR_IDX_NORM_FREQ: prdata_d[15:0] = norm_freq_q;
          `FCR_IDX_STATUS: begin
            prdata_d[1:0] = src_q;
            prdata_d[2]   = gain_q;
            prdata_d[3]   = prev_bit_q;
            prdata_d[4]   = have_prev_q;
          end
          default: prdata_d[15:0] = fsk_q[3'(idx - `FCR_IDX_SPACE_AMP)];
        endcase
      end
    end
    // Software turns the mode on through the control word.
    if (commit && pwrite && mapped) begin
      unique case (idx)
        `FCR_IDX_CTRL:      ctrl_d      = pwdata[1:0];
        `FCR_IDX_NORM_AMP:  norm_amp_d  = pwdata[15:0];
        `FCR_IDX_NORM_FREQ: norm_freq_d = pwdata[15:0];
        `FCR_IDX_STATUS:    ctrl_d      = ctrl_q;
        default: fsk_d[3'(idx - `FCR_IDX_SPACE_AMP)] = pwdata[15:0];
      endcase
    end
  end

  // Asynchronous reset puts every control register at its default.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q      <= `FCR_RST_CTRL;
      norm_amp_q  <= `FCR_RST_COEF;
      norm_freq_q <= `FCR_RST_COEF;
      for (int i = 0; i < `FCR_NUM_SLOTS; i++) begin
        fsk_q[i] <= `FCR_RST_COEF;
      end
      prdata_q    <= 32'h0000_0000;
      pready_q    <= 1'b0;
      pslverr_q   <= 1'b0;
    end else begin
      ctrl_q      <= ctrl_d;
      norm_amp_q  <= norm_amp_d;
      norm_freq_q <= norm_freq_d;
      fsk_q       <= fsk_d;
      prdata_q    <= prdata_d;
      pready_q    <= pready_d;
      pslverr_q   <= pslverr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator reload.

  // On each expiry pick the coefficient pair; the gain correction is folded
  // into the loaded amplitude, so it holds for the whole new symbol.
  always_comb begin
    amp_d       = amp_q;
    freq_d      = freq_q;
    load_d      = 1'b0;
    gain_d      = gain_q;
    src_d       = src_q;
    prev_bit_d  = prev_bit_q;
    have_prev_d = have_prev_q;
    if (!fsk_on) begin
      have_prev_d = 1'b0;
    end
    if (osc_timer_expire) begin
      load_d = 1'b1;
      if (fsk_on && tx_bit) begin
        amp_d       = mark_amp;
        freq_d      = mark_freq;
        src_d       = fcr_pkg::FCR_SRC_MARK;
        gain_d      = change;
        if (change) begin
          amp_d = scale_amp(mark_amp, s2m_gain);
        end
        prev_bit_d  = 1'b1;
        have_prev_d = 1'b1;
      end else if (fsk_on) begin
        amp_d       = space_amp;
        freq_d      = space_freq;
        src_d       = fcr_pkg::FCR_SRC_SPACE;
        gain_d      = change;
        if (change) begin
          amp_d = scale_amp(space_amp, m2s_gain);
        end
        prev_bit_d  = 1'b0;
        have_prev_d = 1'b1;
      end else begin
        amp_d  = norm_amp_q;
        freq_d = norm_freq_q;
        src_d  = fcr_pkg::FCR_SRC_NORMAL;
        gain_d = 1'b0;
      end
    end
  end

  // Reload outputs and symbol history.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      amp_q       <= `FCR_RST_COEF;
      freq_q      <= `FCR_RST_COEF;
      load_q      <= 1'b0;
      gain_q      <= 1'b0;
      src_q       <= fcr_pkg::FCR_SRC_NORMAL;
      prev_bit_q  <= 1'b0;
      have_prev_q <= 1'b0;
    end else begin
      amp_q       <= amp_d;
      freq_q      <= freq_d;
      load_q      <= load_d;
      gain_q      <= gain_d;
      src_q       <= src_d;
      prev_bit_q  <= prev_bit_d;
      have_prev_q <= have_prev_d;
    end
  end

  // Every output comes straight from a flip-flop.
  assign prdata       = prdata_q;
  assign pready       = pready_q;
  assign pslverr      = pslverr_q;
  assign first_oscillator_amplitude_coef = amp_q;
  assign first_oscillator_frequency_coef = freq_q;
  assign first_oscillator_load           = load_q;
  assign gain_applied = gain_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  a_space_amp: assert property (
    @(posedge pclk) disable iff (!presetn)
    osc_timer_expire && fsk_on && !tx_bit && !change
      |=> first_oscillator_load &&
          first_oscillator_amplitude_coef == $past(space_amp))
    else $error("space amplitude not loaded");

  a_space_freq: assert property (
    @(posedge pclk) disable iff (!presetn)
    osc_timer_expire && fsk_on && !tx_bit
      |=> first_oscillator_frequency_coef == $past(space_freq))
    else $error("space frequency not loaded");

  a_mark_amp: assert property (
    @(posedge pclk) disable iff (!presetn)
    osc_timer_expire && fsk_on && tx_bit && !change
      |=> first_oscillator_amplitude_coef == $past(mark_amp) &&
          !gain_applied)
    else $error("mark amplitude not loaded");

  a_mark_freq: assert property (
    @(posedge pclk) disable iff (!presetn)
    osc_timer_expire && fsk_on && tx_bit
      |=> first_oscillator_frequency_coef == $past(mark_freq))
    else $error("mark frequency not loaded");

  a_s2m_gain: assert property (
    @(posedge pclk) disable iff (!presetn)
    osc_timer_expire && fsk_on && tx_bit && change
      |=> gain_applied && first_oscillator_amplitude_coef ==
          scale_amp($past(mark_amp), $past(s2m_gain)))
    else $error("space-to-mark gain not applied");

  a_m2s_gain: assert property (
    @(posedge pclk) disable iff (!presetn)
    osc_timer_expire && fsk_on && !tx_bit && change
      |=> gain_applied && first_oscillator_amplitude_coef ==
          scale_amp($past(space_amp), $past(m2s_gain)))
    else $error("mark-to-space gain not applied");

  // Checked from the second edge in reset on, so the very first edge after
  // power-up, where the flops may not have seen the reset yet, is skipped.
  a_reset_ctrl: assert property (
    @(posedge pclk)
    !presetn && !$past(presetn) |-> ctrl_q == `FCR_RST_CTRL &&
      space_amp == `FCR_RST_COEF && m2s_gain == `FCR_RST_COEF &&
      !first_oscillator_load)
    else $error("registers not at default in reset");

  a_normal_load: assert property (
    @(posedge pclk) disable iff (!presetn)
    osc_timer_expire && !fsk_on |=> first_oscillator_load &&
      !gain_applied &&
      first_oscillator_amplitude_coef == $past(norm_amp_q) &&
      first_oscillator_frequency_coef == $past(norm_freq_q))
    else $error("normal coefficients not loaded");

  a_ctrl_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    commit && pwrite && paddr == 12'h000 |=> ctrl_q == $past(pwdata[1:0]))
    else $error("control write lost");

  a_apb_wait: assert property (
    @(posedge pclk) disable iff (!presetn)
    psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb answer not after one wait state");

  a_load_pulse: assert property (
    @(posedge pclk) disable iff (!presetn)
    !osc_timer_expire |=> !first_oscillator_load)
    else $error("reload strobe without expiry");

  a_bad_addr: assert property (
    @(posedge pclk) disable iff (!presetn)
    access && !pready_q && !mapped |=> pready && pslverr)
    else $error("unmapped access not refused");

  a_status_ro: assert property (
    @(posedge pclk) disable iff (!presetn)
    commit && pwrite && idx == `FCR_IDX_STATUS |=> $stable(ctrl_q))
    else $error("status write changed control");

  // Main scenarios the bench is expected to reach.
  c_transition: cover property (@(posedge pclk) disable iff (!presetn)
    osc_timer_expire && fsk_on && change);
  c_normal: cover property (@(posedge pclk) disable iff (!presetn)
    osc_timer_expire && !fsk_on);
  c_bad_addr: cover property (@(posedge pclk) disable iff (!presetn)
    pready && pslverr);
  c_saturate: cover property (@(posedge pclk) disable iff (!presetn)
    first_oscillator_load && first_oscillator_amplitude_coef == 16'hFFFF);
  c_status_write: cover property (@(posedge pclk) disable iff (!presetn)
    commit && pwrite && idx == `FCR_IDX_STATUS);

endmodule

// *** bench/fcr_top_tb_top.sv ***
// Purpose: Self-checking bench for the shift-keying coefficient reload.
// Assumes: APB slave answers in its own time; expiry is a one-cycle pulse.
// Notes:   Expected values are worked out here, never read from the design.
`timescale 1ns/100ps
`include "fcr_cfg.svh"

module fcr_top_tb_top;
  logic               pclk, presetn, psel, penable, pwrite;
  logic        [11:0] paddr;
  logic        [31:0] pwdata, prdata, rd;
  logic               pready, pslverr, osc_timer_expire, tx_bit, er;
  fcr_pkg::fcr_coef_t osc_amp, osc_freq;
  logic               osc_load, gain_applied;
  int                 bad_count, check_count;

  fcr_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .osc_timer_expire(osc_timer_expire), .tx_bit(tx_bit),
    .first_oscillator_amplitude_coef(osc_amp),
    .first_oscillator_frequency_coef(osc_freq),
    .first_oscillator_load(osc_load),
    .gain_applied(gain_applied));

  ////////////////////////////////////////////////////////////////////////////
  // Clock at 20 MHz and all inputs quiet at time zero.
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  initial begin
    {presetn, psel, penable, pwrite, osc_timer_expire, tx_bit} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks: compare, APB transfer, timer expiry.
  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  // The request stands until pready is sampled high; no wait is assumed.
  task automatic apb(input logic wr, input logic [7:0] idx,
                     input logic [31:0] wd, output logic [31:0] rdo,
                     output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {2'h0, idx, 2'h0};
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // A slave that never answers is caught by the watchdog alone.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdo = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0, rd, er);
    chk("read data", rd, exp);
    chk("read error", {31'h0, er}, 32'h0);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    apb(1'b1, idx, wd, rd, er);
  endtask

  // One expiry pulse; the load shows for one cycle after the taking edge.
  task automatic expire(input logic b, input logic [15:0] ea, ef,
                        input logic eg);
    @(posedge pclk);
    osc_timer_expire <= 1'b1;
    tx_bit           <= b;
    @(posedge pclk);
    osc_timer_expire <= 1'b0;
    #1;
    chk("osc_load", {31'h0, osc_load}, 32'h1);
    chk("osc_amp", {16'h0, osc_amp}, {16'h0, ea});
    chk("osc_freq", {16'h0, osc_freq}, {16'h0, ef});
    chk("gain_applied", {31'h0, gain_applied}, {31'h0, eg});
    @(posedge pclk);
    #1;
    chk("osc_load low", {31'h0, osc_load}, 32'h0);
  endtask

  // Unsigned gain with 14 fraction bits, saturating at full scale.
  function automatic logic [15:0] scale(input logic [15:0] a, g);
    logic [31:0] p;
    p = ({16'h0, a} * {16'h0, g}) >> `FCR_GAIN_FRAC;
    return (p > 32'h0000_FFFF) ? 16'hFFFF : p[15:0];
  endfunction

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog sized well above the few hundred cycles the tests need.
  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    final_report();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  logic [15:0] cv [6];
  initial begin
    cv = '{16'h2000, 16'h1111, 16'h3000, 16'h2222, 16'h8000, 16'h2000};
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(`FCR_IDX_CTRL, 32'h0);
    for (int i = 0; i < 6; i++) rd_chk(8'h45 + i[7:0], 32'h0);
    for (int i = 0; i < 6; i++) wr(8'h45 + i[7:0], {16'h0, cv[i]});
    for (int i = 0; i < 6; i++) begin
      rd_chk(8'h45 + i[7:0], {16'h0, cv[i]});
    end
    apb(1'b1, 8'h10, 32'h5A5A, rd, er);
    chk("unmapped write error", {31'h0, er}, 32'h1);
    apb(1'b0, 8'h10, 32'h0, rd, er);
    chk("unmapped read", {er, rd[30:0]}, 32'h8000_0000);
    $display("test registers done");
    // Mode off: normal pair, no correction.
    wr(`FCR_IDX_NORM_AMP, 32'h0000_0ABC);
    wr(`FCR_IDX_NORM_FREQ, 32'h0000_0DEF);
    expire(1'b1, 16'h0ABC, 16'h0DEF, 1'b0);
    // Both flags on: first symbol has no previous, so no gain.
    wr(`FCR_IDX_CTRL, 32'h3);
    expire(1'b0, cv[0], cv[1], 1'b0);
    expire(1'b0, cv[0], cv[1], 1'b0);
    expire(1'b1, scale(cv[2], cv[4]), cv[3], 1'b1);
    expire(1'b1, cv[2], cv[3], 1'b0);
    expire(1'b0, scale(cv[0], cv[5]), cv[1], 1'b1);
    wr(`FCR_IDX_MARK_AMP, 32'h0000_C000);
    expire(1'b1, 16'hFFFF, cv[3], 1'b1);
    // Status: mark source, gain on, previous bit 1, previous valid.
    rd_chk(`FCR_IDX_STATUS, 32'h0000_001E);
    wr(`FCR_IDX_STATUS, 32'h0000_0000);
    rd_chk(`FCR_IDX_STATUS, 32'h0000_001E);
    rd_chk(`FCR_IDX_NORM_AMP, 32'h0000_0ABC);
    rd_chk(`FCR_IDX_NORM_FREQ, 32'h0000_0DEF);
    $display("test shift keying done");
    // One flag alone falls back to the normal pair.
    wr(`FCR_IDX_CTRL, 32'h1);
    expire(1'b0, 16'h0ABC, 16'h0DEF, 1'b0);
    wr(`FCR_IDX_CTRL, 32'h2);
    expire(1'b1, 16'h0ABC, 16'h0DEF, 1'b0);
    wr(`FCR_IDX_CTRL, 32'h3);
    expire(1'b1, 16'hC000, cv[3], 1'b0);
    $display("test single flag done");
    // Reset in mid-run clears control and coefficients.
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(`FCR_IDX_CTRL, 32'h0);
    for (int i = 0; i < 6; i++) rd_chk(8'h45 + i[7:0], 32'h0);
    expire(1'b1, 16'h0000, 16'h0000, 1'b0);
    $display("test mid-run reset done");
    final_report();
  end
endmodule
